/* hw/failsafe_init_config.v */
`timescale 1ns/1ns
`include "failsafe_init_regs.vh"
module failsafe_init_config #(
  parameter RST_LONG_CYCLES  = `RST_LONG_US * `CLK_MHZ,
  parameter RST_SHORT_CYCLES = `RST_SHORT_US * `CLK_MHZ
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire        frame_valid,
  input  wire [15:0] frame_in,
  input  wire [11:0] global_status,
  output reg         reply_valid,
  output reg  [15:0] reply_out,
  output reg         write_reject,
  input  wire [2:0]  fault_error_count,
  input  wire [1:0]  watchdog_error_count,
  input  wire [1:0]  watchdog_error_limit,
  input  wire        can_disable_choice,
  input  wire        delayed_failsafe_output_n,
  input  wire        io4_pin,
  input  wire        io5_pin,
  output reg  [2:0]  thr_intermediate,
  output reg  [2:0]  thr_final,
  output reg         can_rx_only,
  output reg         can_sleep,
  output reg         primary_failsafe_output_n,
  output reg         reset_output_n,
  output reg         safety_input_pairing,
  output reg  [1:0]  safety_inputs
);
  localparam [`RST_CNT_W-1:0] LONG_C  = RST_LONG_CYCLES[`RST_CNT_W-1:0];
  localparam [`RST_CNT_W-1:0] SHORT_C = RST_SHORT_CYCLES[`RST_CNT_W-1:0];

  reg  [3:0] fault_cfg_r;
  reg  [1:0] safety_init_r;
  reg        rst_req_d_r;
  reg  [`RST_CNT_W-1:0] rst_cnt_r;
  reg  [`RST_CNT_W-1:0] rst_cnt_nxt;

  wire [2:0] pins_s;
  wire       fs1_low;
  wire [4:0] addr;
  wire [3:0] data;
  wire [3:0] sec;
  wire       is_fault;
  wire       is_fss;
  wire       parity_ok;
  wire       secure_ok;
  wire       wr_ok;
  wire [1:0] effect;
  wire       flt_cond;
  wire       wd_cond;
  wire       fs0_req;
  wire       rst_req;
  wire       limit_fast;
  wire       can_impact;
  wire       pairing_on;
  wire       pulse_len_short;
  wire       pulse_start;
  reg  [3:0] rd_nibble;

  sync_2ff #(
    .W (3)
  ) u_sync (
    .mclk (mclk),
    .rst  (rst),
    .d    ({delayed_failsafe_output_n, io5_pin, io4_pin}),
    .q    (pins_s)
  );

  assign fs1_low   = ~pins_s[2];
  assign addr      = frame_in[`FRM_ADDR_HI:`FRM_ADDR_LO];
  assign data      = frame_in[`FRM_DATA_HI:`FRM_DATA_LO];
  assign sec       = frame_in[`FRM_SEC_HI:`FRM_SEC_LO];
  assign is_fault  = frame_in[`FRM_FIXED_BIT] & (addr == `ADDR_FAULT_CFG);
  assign is_fss    = frame_in[`FRM_FIXED_BIT] & (addr == `ADDR_SAFETY_INIT);
  // Odd parity over the whole write frame
  assign parity_ok = ^frame_in;
  assign secure_ok = (sec == {~data[1], ~data[0], data[3], data[2]});
  assign wr_ok     = frame_in[`FRM_WRITE_BIT] & parity_ok & secure_ok;

  // Configuration storage
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      fault_cfg_r   <= `FAULT_CFG_RESET;
      safety_init_r <= `SAFETY_INIT_RESET;
    end
    else if (frame_valid && wr_ok)
    begin
      if (is_fault)
        fault_cfg_r <= data;
      if (is_fss)
        safety_init_r <= {data[`FSS_PAIRING_BIT], data[`FSS_PULSE_LEN_BIT]};
    end
  end

  always @*
  begin
    rd_nibble = 4'h0;
    if (is_fault)
      rd_nibble = fault_cfg_r;
    else if (is_fss)
      rd_nibble = {safety_init_r[1], 2'h0, safety_init_r[0]};
  end

  // Reply carries contents as they stood before this frame
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      reply_valid  <= 1'b0;
      reply_out    <= 16'h0000;
      write_reject <= 1'b0;
    end
    else
    begin
      reply_valid  <= frame_valid & (is_fault | is_fss);
      write_reject <= frame_valid & (is_fault | is_fss)
                      & frame_in[`FRM_WRITE_BIT] & ~wr_ok;
      if (frame_valid && (is_fault || is_fss))
        reply_out <= {global_status, rd_nibble};
    end
  end

  assign effect   = fault_cfg_r[`FLT_EFFECT_HI:`FLT_EFFECT_LO];
  assign flt_cond = (fault_error_count >= thr_intermediate);
  assign wd_cond  = (watchdog_error_count == watchdog_error_limit);
  assign fs0_req  = flt_cond & ((effect == `EFFECT_FS0) |
                                (effect == `EFFECT_BOTH));
  assign rst_req  = flt_cond & wd_cond & ((effect == `EFFECT_RST) |
                                          (effect == `EFFECT_BOTH));

  assign limit_fast      = fault_cfg_r[`FLT_LIMIT_SEL_BIT];
  assign can_impact      = fault_cfg_r[`FLT_CAN_IMPACT_BIT];
  assign pairing_on      = safety_init_r[1];
  assign pulse_len_short = safety_init_r[0];
  assign pulse_start     = rst_req & ~rst_req_d_r;

  // Reset pulse counter, started on a new request
  always @*
  begin
    rst_cnt_nxt = rst_cnt_r;
    if (pulse_start)
      rst_cnt_nxt = pulse_len_short ? SHORT_C : LONG_C;
    else if (rst_cnt_r != {`RST_CNT_W{1'b0}})
      rst_cnt_nxt = rst_cnt_r - {{(`RST_CNT_W-1){1'b0}}, 1'b1};
  end

  // Request edge detector and pulse counter
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rst_req_d_r <= 1'b0;
      rst_cnt_r   <= {`RST_CNT_W{1'b0}};
    end
    else
    begin
      rst_req_d_r <= rst_req;
      rst_cnt_r   <= rst_cnt_nxt;
    end
  end

  // Thresholds follow the limit selector
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      thr_intermediate <= `THR_INTER_NORMAL;
      thr_final        <= `THR_FINAL_NORMAL;
    end
    else
    begin
      thr_intermediate <= limit_fast ? `THR_INTER_FAST
                                     : `THR_INTER_NORMAL;
      thr_final        <= limit_fast ? `THR_FINAL_FAST
                                     : `THR_FINAL_NORMAL;
    end
  end

  // CAN reaction while the delayed output is low
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      can_rx_only <= 1'b0;
      can_sleep   <= 1'b0;
    end
    else
    begin
      can_rx_only <= can_impact & fs1_low & ~can_disable_choice;
      can_sleep   <= can_impact & fs1_low & can_disable_choice;
    end
  end

  // Fail-safe and reset outputs, both active low
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      primary_failsafe_output_n <= 1'b1;
      reset_output_n            <= 1'b1;
    end
    else
    begin
      primary_failsafe_output_n <= ~fs0_req;
      reset_output_n <= (rst_cnt_nxt == {`RST_CNT_W{1'b0}});
    end
  end

  // Paired safety inputs, blanked when not paired
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      safety_input_pairing <= 1'b0;
      safety_inputs        <= 2'h0;
    end
    else
    begin
      safety_input_pairing <= pairing_on;
      safety_inputs        <= pairing_on ? pins_s[1:0] : 2'h0;
    end
  end
endmodule // failsafe_init_config

/* hw/failsafe_init_regs.vh */
`ifndef FAILSAFE_INIT_REGS_VH
`define FAILSAFE_INIT_REGS_VH

// Frame layout
`define FRM_WRITE_BIT      15
`define FRM_FIXED_BIT      14
`define FRM_ADDR_HI        13
`define FRM_ADDR_LO        9
`define FRM_PARITY_BIT     8
`define FRM_DATA_HI        7
`define FRM_DATA_LO        4
`define FRM_SEC_HI         3
`define FRM_SEC_LO         0

// Register address patterns, frame bits 13..9
`define ADDR_FAULT_CFG     5'h04
`define ADDR_SAFETY_INIT   5'h05

// Field positions inside the 4-bit data nibble
`define FLT_LIMIT_SEL_BIT  3
`define FLT_CAN_IMPACT_BIT 2
`define FLT_EFFECT_HI      1
`define FLT_EFFECT_LO      0
`define FSS_PAIRING_BIT    3
`define FSS_PULSE_LEN_BIT  0

// Reset values
`define FAULT_CFG_RESET    4'h0
`define SAFETY_INIT_RESET  2'h0

// Fault counter thresholds
`define THR_INTER_NORMAL   3'h3
`define THR_FINAL_NORMAL   3'h6
`define THR_INTER_FAST     3'h1
`define THR_FINAL_FAST     3'h2

// Output effect encodings
`define EFFECT_NONE        2'h0
`define EFFECT_FS0         2'h1
`define EFFECT_RST         2'h2
`define EFFECT_BOTH        2'h3

// Timing
`define CLK_MHZ            125
`define RST_LONG_US        10000
`define RST_SHORT_US       1000
`define RST_CNT_W          21

`endif

/* hw/sync_2ff.v */
`timescale 1ns/1ns
module sync_2ff #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end
    else
    begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule // sync_2ff

/* testbench/failsafe_init_config_sva.sv */
`timescale 1ns/1ns
module fic_chk #(
  parameter int RST_LONG_CYCLES  = 20,
  parameter int RST_SHORT_CYCLES = 5
) (
  input wire        mclk,
  input wire        rst,
  input wire        frame_valid,
  input wire [15:0] frame_in,
  input wire        reply_valid,
  input wire        write_reject,
  input wire [2:0]  thr_intermediate,
  input wire [2:0]  thr_final,
  input wire        can_rx_only,
  input wire        can_sleep,
  input wire        can_disable_choice,
  input wire        reset_output_n,
  input wire        safety_input_pairing,
  input wire [1:0]  safety_inputs
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_thr; thr_final == (thr_intermediate == 3'h3 ? 3'h6 : 3'h2);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold pair");
  property p_rep; frame_valid && frame_in[14] && frame_in[13:10] == 4'h2
    |=> reply_valid; endproperty
  a_rep: assert property (p_rep) else $error("no reply");
  property p_norep; !frame_valid |=> !reply_valid; endproperty
  a_norep: assert property (p_norep) else $error("stray reply");
  property p_rej; write_reject |-> reply_valid; endproperty
  a_rej: assert property (p_rej) else $error("reject alone");
  property p_can; !(can_rx_only && can_sleep); endproperty
  a_can: assert property (p_can) else $error("both CAN modes");
  property p_csl; can_sleep |-> $past(can_disable_choice); endproperty
  a_csl: assert property (p_csl) else $error("sleep not chosen");
  property p_crx; can_rx_only |-> !$past(can_disable_choice); endproperty
  a_crx: assert property (p_crx) else $error("rx-only not chosen");
  property p_pair; !safety_input_pairing && !$past(safety_input_pairing)
    |-> safety_inputs == 2'h0; endproperty
  a_pair: assert property (p_pair) else $error("inputs unpaired");
  property p_rlow; $fell(reset_output_n) |-> !reset_output_n [*5];
  endproperty
  a_rlow: assert property (p_rlow) else $error("reset short");
  property p_rhi; $fell(reset_output_n)
    |-> ##[RST_SHORT_CYCLES:RST_LONG_CYCLES] reset_output_n; endproperty
  a_rhi: assert property (p_rhi) else $error("reset long");
  c_rep: cover property (reply_valid);
  c_rej: cover property (write_reject);
  c_rst: cover property ($fell(reset_output_n));
endmodule // fic_chk
bind failsafe_init_config fic_chk #(.RST_LONG_CYCLES(RST_LONG_CYCLES),
  .RST_SHORT_CYCLES(RST_SHORT_CYCLES)) chk (.mclk, .rst, .frame_valid,
  .frame_in, .reply_valid, .write_reject, .thr_intermediate, .thr_final,
  .can_rx_only, .can_sleep, .can_disable_choice, .reset_output_n,
  .safety_input_pairing,
  .safety_inputs);

/* testbench/failsafe_init_config_tb.sv */
`timescale 1ns/1ns
`define CK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin \
  bad_count = bad_count + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module failsafe_init_config_tb;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg  [11:0] gs = 12'ha5c;
  reg  [2:0]  fec = 3'h7;
  reg  [1:0]  wdc = 2'h0;
  reg  [1:0]  wdl = 2'h1;
  reg         cdc = 1'b0;
  reg         dfo_n = 1'b1;
  reg  [1:0]  io = 2'h0;
  wire        fv, rv, rej, cro, csl, fs0_n, rst_n, pair;
  wire [15:0] fin, rep;
  wire [2:0]  ti, tf;
  wire [1:0]  si;
  integer     bad_count = 0;
  integer     num_checks = 0;
  integer     i, n;
  always #4 mclk = ~mclk;
  host_model host (.mclk(mclk), .frame_valid(fv), .frame_in(fin));
  failsafe_init_config #(.RST_LONG_CYCLES(20), .RST_SHORT_CYCLES(5)) dut (
    .mclk(mclk), .rst(rst), .frame_valid(fv), .frame_in(fin),
    .global_status(gs), .reply_valid(rv), .reply_out(rep),
    .write_reject(rej), .fault_error_count(fec), .watchdog_error_count(wdc),
    .watchdog_error_limit(wdl), .can_disable_choice(cdc),
    .delayed_failsafe_output_n(dfo_n), .io4_pin(io[0]), .io5_pin(io[1]),
    .thr_intermediate(ti), .thr_final(tf), .can_rx_only(cro),
    .can_sleep(csl), .primary_failsafe_output_n(fs0_n),
    .reset_output_n(rst_n), .safety_input_pairing(pair),
    .safety_inputs(si));
  task pulse(input integer exp);
    begin
      @(negedge mclk);
      fec = 3'h3;
      n = 0;
      for (i = 0; i < 60; i = i + 1)
      begin
        @(negedge mclk);
        if (rst_n !== 1'b1) n = n + 1;
      end
      fec = 3'h0;
      `CK(n, exp)
    end
  endtask
  task t_init;
    begin
      host.xfer(1'b0, 5'h04, 4'h0, 2'h0);
      `CK({rv, rep}, {1'b1, gs, 4'h0})
      host.xfer(1'b0, 5'h05, 4'h0, 2'h0);
      `CK({rv, rep}, {1'b1, gs, 4'h0})
      `CK({ti, tf, fs0_n, rst_n}, {3'h3, 3'h6, 2'h3})
      $display("t_init done");
    end
  endtask
  task t_reject;
    begin
      host.xfer(1'b1, 5'h04, 4'h9, 2'h1);
      `CK({rv, rej}, 2'h3)
      host.xfer(1'b0, 5'h04, 4'h0, 2'h0);
      `CK({rej, rep[3:0]}, 5'h00)
      $display("t_reject done");
    end
  endtask
  task t_rst;
    begin
      fec = 3'h0;
      wdc = 2'h1;
      host.xfer(1'b1, 5'h04, 4'h2, 2'h0);
      `CK(rej, 1'b0)
      pulse(20);
      `CK(fs0_n, 1'b1)
      io = 2'h1;
      host.xfer(1'b1, 5'h05, 4'h9, 2'h0);
      pulse(5);
      `CK({pair, si}, 3'h5)
      $display("t_rst done");
    end
  endtask
  task t_fault;
    begin
      host.xfer(1'b1, 5'h04, 4'hd, 2'h0);
      `CK(rep[3:0], 4'h2)
      fec = 3'h1;
      dfo_n = 1'b0;
      repeat (5) @(negedge mclk);
      `CK({ti, tf, fs0_n, cro, csl}, {3'h1, 3'h2, 3'h2})
      cdc = 1'b1;
      repeat (3) @(negedge mclk);
      `CK({cro, csl}, 2'h1)
      host.xfer(1'b0, 5'h04, 4'h0, 2'h0);
      `CK(rep[3:0], 4'hd)
      $display("t_fault done");
    end
  endtask
  task t_reset;
    begin
      @(negedge mclk);
      rst = 1'b1;
      fec = 3'h0;
      dfo_n = 1'b1;
      cdc = 1'b0;
      repeat (2) @(negedge mclk);
      `CK(rep, 16'h0000)
      `CK({ti, tf, fs0_n, rst_n}, {3'h3, 3'h6, 2'h3})
      `CK({csl, pair, si, rv}, 5'h00)
      rst = 1'b0;
      host.xfer(1'b0, 5'h04, 4'h0, 2'h0);
      `CK({rv, rep}, {1'b1, gs, 4'h0})
      host.xfer(1'b0, 5'h05, 4'h0, 2'h0);
      `CK({rv, rep}, {1'b1, gs, 4'h0})
      $display("t_reset done");
    end
  endtask
  task t_both;
    begin
      wdc = 2'h2;
      dfo_n = 1'b0;
      host.xfer(1'b1, 5'h04, 4'h3, 2'h0);
      `CK(rej, 1'b0)
      fec = 3'h3;
      repeat (3) @(negedge mclk);
      `CK({fs0_n, rst_n, cro, csl}, 4'h4)
      fec = 3'h0;
      dfo_n = 1'b1;
      wdl = 2'h2;
      pulse(20);
      host.xfer(1'b1, 5'h04, 4'h0, 2'h2);
      `CK({rv, rej}, 2'h3)
      host.xfer(1'b0, 5'h04, 4'h0, 2'h0);
      `CK(rep[3:0], 4'h3)
      host.xfer(1'b0, 5'h06, 4'h0, 2'h0);
      `CK(rv, 1'b0)
      $display("t_both done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    t_init;
    t_reject;
    t_rst;
    t_fault;
    t_reset;
    t_both;
    give_verdict;
  end
endmodule // failsafe_init_config_tb

/* testbench/host_model.sv */
`timescale 1ns/1ns
module host_model (
  input  wire        mclk,
  output reg         frame_valid,
  output reg  [15:0] frame_in
);
  reg [15:0] f;
  initial frame_valid = 1'b0;
  initial frame_in = 16'h0000;
  // Bad bit 0 flips a check bit, bit 1 the parity
  task xfer(input w, input [4:0] a, input [3:0] d, input [1:0] bad);
    begin
      f = {w, 1'b1, a, 1'b0, w ? d : 4'h0, 4'h0};
      if (w) f[3:0] = {~d[1], ~d[0], d[3], d[2]} ^ {3'h0, bad[0]};
      if (w) f[8] = ~^f ^ bad[1];
      @(negedge mclk);
      frame_valid = 1'b1;
      frame_in = f;
      @(negedge mclk);
      frame_valid = 1'b0;
      frame_in = ~f;
    end
  endtask
endmodule // host_model
